/* File: umqs_host.sv */
// Host-side sequencer for a SPI-to-UART daisy-chain bridge: builds a
// broadcast write or read, queues and sends it, polls for the answer,
// reads it back, checks it and inspects the bridge's error state.
// Assumes the bridge answers on SPI mode 0 and that software uses the
// plain register port.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module umqs_host
   import umqs_pkg::*;
#(
   parameter int POLL_TOUT_CYC = umqs_pkg::POLL_TOUT_CYC_DEF,
   parameter logic [7:0] FAULT_MON_RD_CMD = umqs_pkg::FAULT_MON_RD_DEF
) (
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic [3:0] SW_ADDR,
   input wire logic [15:0] SW_WDATA,
   input wire logic SW_WR,
   input wire logic SW_RD,
   output logic [15:0] SW_RDATA,
   output logic IRQ,
   output logic SPI_SCLK,
   output logic SPI_MOSI,
   input wire logic SPI_MISO,
   output logic SPI_CS_N
);
   umqs_byte_if lk ();
   umqs_state_type st_q, st_d;
   logic [3:0] idx_q, idx_d, cnt, kl, kr;
   logic pend_q, pend_d, last_b, go;
   logic [7:0] crc_q, crc_d, crc_in, crc_nx, tx_b, seed_q, seed_d;
   logic [7:0] stat_q, stat_d, flags_q, flags_d, fmon_q, fmon_d;
   logic [7:0] rxd_q [2*NUM_DEV];
   logic [7:0] rxd_d [2*NUM_DEV];
   logic [15:0] tout_q, tout_d;
   logic [EV_W-1:0] ev_set, ev_q, ev_d, en_q, en_d;
   logic rd_op_q, rd_op_d, alive_q, alive_d;
   logic [7:0] addr_q, addr_d;
   logic [15:0] wdat_q, wdat_d, rdata_q, rdata_d;

   umqs_spi_byte u_spi (.clk(CORE_CLK), .rst_n(NRST), .lk(lk), .miso(SPI_MISO),
      .mosi(SPI_MOSI), .sclk(SPI_SCLK), .cs_n(SPI_CS_N));
   umqs_crc8 u_crc (.crc_in(crc_q), .data_in(crc_in), .crc_out(crc_nx));

   // ==========================================================
   // Byte selection per phase
   assign kl = idx_q - LD_HDR;
   assign kr = idx_q - RX_HDR;
   always_comb begin
      tx_b = DUMMY_BYTE;
      cnt = TWO_CNT;
      case (st_q)
         S_LOAD: begin
            cnt = rd_op_q ? LD_RD_CNT : LD_WR_CNT;
            if (idx_q == 4'h0) begin
               tx_b = LOAD_QUEUE_WRITE_CMD;
            end else if (idx_q == ONE_CNT) begin
               tx_b = rd_op_q ? RD_LEN_B : WR_LEN_B;
            end else if (kl == 4'h0) begin
               tx_b = rd_op_q ? BROADCAST_READ_MSG : BROADCAST_WRITE_MSG;
            end else if (kl == MP_ADDR) begin
               tx_b = addr_q;
            end else if (rd_op_q) begin
               // Read: data-check seed, PEC, alive seed
               tx_b = (kl == MP_LO) ? DC_SEED : (kl == MP_PEC_RD) ? crc_q : seed_q;
            end else begin
               // Write: data, PEC, then alive seed outside the PEC
               tx_b = (kl == MP_LO) ? wdat_q[7:0] : (kl == MP_HI) ? wdat_q[15:8] :
                  (kl == MP_PEC_WR) ? crc_q : seed_q;
            end
         end
         S_START: begin
            cnt = ONE_CNT;
            tx_b = NEXT_QUEUE_SEND_CMD;
         end
         S_POLL: tx_b = (idx_q == 4'h0) ? RX_STATUS_RD_CMD : DUMMY_BYTE;
         S_READ: begin
            cnt = rd_op_q ? RX_RD_CNT : RX_WR_CNT;
            tx_b = (idx_q == 4'h0) ? NEXT_MESSAGE_READ_CMD : DUMMY_BYTE;
         end
         S_FLAGS: tx_b = (idx_q == 4'h0) ? RX_FLAGS_RD_CMD : DUMMY_BYTE;
         S_FMON: tx_b = (idx_q == 4'h0) ? FAULT_MON_RD_CMD : DUMMY_BYTE;
         S_CLEAR: tx_b = (idx_q == 4'h0) ? RX_FLAGS_WR_CMD : FLAGS_CLR;
         default: tx_b = DUMMY_BYTE;
      endcase
   end

   assign last_b = (idx_q == cnt - ONE_CNT);
   assign crc_in = (st_q == S_READ) ? lk.rx : tx_b;
   assign lk.tx = tx_b;
   assign lk.last = last_b;
   assign lk.req = !pend_q && lk.ready && st_q != S_IDLE && st_q != S_DONE;

   // ==========================================================
   // Sequencer
   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      pend_d = pend_q;
      crc_d = crc_q;
      seed_d = seed_q;
      stat_d = stat_q;
      flags_d = flags_q;
      fmon_d = fmon_q;
      rxd_d = rxd_q;
      ev_set = '0;
      tout_d = (tout_q == 16'hffff) ? tout_q : tout_q + 16'h0001;
      if (lk.req) begin
         pend_d = 1'b1;
      end
      if (st_q == S_IDLE && go) begin
         st_d = S_LOAD;
         idx_d = 4'h0;
         crc_d = PEC_INIT;
      end else if (st_q == S_DONE) begin
         // Fresh alive seed per message tells repeated polls apart
         seed_d = seed_q + SEED_STEP;
         ev_set[EV_DONE] = 1'b1;
         st_d = S_IDLE;
      end
      if (lk.done) begin
         pend_d = 1'b0;
         idx_d = last_b ? 4'h0 : idx_q + ONE_CNT;
         case (st_q)
            S_LOAD: begin
               if (idx_q >= LD_HDR && kl < (rd_op_q ? MP_PEC_RD : MP_PEC_WR)) begin
                  crc_d = crc_nx;
               end
               if (last_b) begin
                  st_d = S_START;
               end
            end
            S_START: begin
               tout_d = 16'h0000;
               st_d = S_POLL;
            end
            S_POLL: begin
               if (last_b) begin
                  stat_d = lk.rx;
                  if (lk.rx[STATUS_MSG_BIT]) begin
                     st_d = S_READ;
                     crc_d = PEC_INIT;
                  end else if (tout_q >= 16'(POLL_TOUT_CYC)) begin
                     // Sent message never came back: lost on the chain
                     ev_set[EV_LOST] = 1'b1;
                     st_d = S_FLAGS;
                  end
               end
            end
            S_READ: begin
               if (idx_q != 4'h0) begin
                  if (kr < (rd_op_q ? MP_RPEC_RD : MP_PEC_WR)) begin
                     crc_d = crc_nx;
                  end
                  if ((kr == 4'h0 && lk.rx != (rd_op_q ? BROADCAST_READ_MSG : BROADCAST_WRITE_MSG))
                     || (kr == MP_ADDR && lk.rx != addr_q)
                     || (rd_op_q && kr == MP_DC_RD && lk.rx != DC_SEED)) begin
                     ev_set[EV_CHECK] = 1'b1;
                  end
                  if (rd_op_q && kr >= MP_DATA0 && kr < MP_DC_RD) begin
                     rxd_d[2'(kr - MP_DATA0)] = lk.rx;
                  end
                  if (kr == (rd_op_q ? MP_RPEC_RD : MP_PEC_WR) && lk.rx != crc_q) begin
                     ev_set[EV_PEC] = 1'b1;
                  end
                  if (last_b && alive_q && lk.rx != seed_q + ALIVE_INC) begin
                     ev_set[EV_ALIVE] = 1'b1;
                  end
               end
               if (last_b) begin
                  st_d = S_FLAGS;
               end
            end
            S_FLAGS: begin
               if (last_b) begin
                  flags_d = lk.rx;
                  ev_set[EV_FLAGS] = (lk.rx != FLAGS_OK);
                  st_d = S_FMON;
               end
            end
            S_FMON: begin
               if (last_b) begin
                  fmon_d = lk.rx;
                  ev_set[EV_FAULT] = (lk.rx != FLAGS_OK);
                  st_d = (flags_q != FLAGS_OK) ? S_CLEAR : S_DONE;
               end
            end
            S_CLEAR: begin
               if (last_b) begin
                  st_d = S_DONE;
               end
            end
            default: st_d = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         st_q <= S_IDLE;
         idx_q <= 4'h0;
         pend_q <= 1'b0;
         crc_q <= PEC_INIT;
         seed_q <= 8'h00;
         stat_q <= 8'h00;
         flags_q <= 8'h00;
         fmon_q <= 8'h00;
         tout_q <= 16'h0000;
         rxd_q <= '{default: 8'h00};
      end else begin
         st_q <= st_d;
         idx_q <= idx_d;
         pend_q <= pend_d;
         crc_q <= crc_d;
         seed_q <= seed_d;
         stat_q <= stat_d;
         flags_q <= flags_d;
         fmon_q <= fmon_d;
         tout_q <= tout_d;
         rxd_q <= rxd_d;
      end
   end

   // ==========================================================
   // Software register port; an event set wins over a same-cycle clear
   assign go = SW_WR && SW_ADDR == REG_CTRL && SW_WDATA[CTRL_GO];
   always_comb begin
      rd_op_d = rd_op_q;
      alive_d = alive_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      en_d = en_q;
      ev_d = ev_q | ev_set;
      rdata_d = 16'h0000;
      if (SW_WR) begin
         case (SW_ADDR)
            REG_CTRL: begin
               // Operation latched only when idle, so a busy write is ignored
               if (st_q == S_IDLE) begin
                  rd_op_d = SW_WDATA[CTRL_READ];
                  alive_d = SW_WDATA[CTRL_ALIVE];
               end
            end
            REG_ADDR: addr_d = SW_WDATA[7:0];
            REG_WDATA: wdat_d = SW_WDATA;
            REG_EVCLR: ev_d = (ev_q & ~SW_WDATA[EV_W-1:0]) | ev_set;
            REG_EVEN: en_d = SW_WDATA[EV_W-1:0];
            default: en_d = en_q;
         endcase
      end
      if (SW_RD) begin
         case (SW_ADDR)
            REG_CTRL: rdata_d = {13'h0000, alive_q, rd_op_q, 1'b0};
            REG_ADDR: rdata_d = {8'h00, addr_q};
            REG_WDATA: rdata_d = wdat_q;
            REG_STATUS: rdata_d = {7'h00, (st_q != S_IDLE), stat_q};
            REG_EVT: rdata_d = {9'h000, ev_q};
            REG_EVEN: rdata_d = {9'h000, en_q};
            REG_FLAGS: rdata_d = {fmon_q, flags_q};
            REG_DEV0: rdata_d = {rxd_q[DEV0_LO+1], rxd_q[DEV0_LO]};
            REG_DEV1: rdata_d = {rxd_q[DEV1_LO+1], rxd_q[DEV1_LO]};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rd_op_q <= 1'b0;
         alive_q <= 1'b0;
         addr_q <= 8'h00;
         wdat_q <= 16'h0000;
         en_q <= '0;
         ev_q <= '0;
         rdata_q <= 16'h0000;
      end else begin
         rd_op_q <= rd_op_d;
         alive_q <= alive_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         en_q <= en_d;
         ev_q <= ev_d;
         rdata_q <= rdata_d;
      end
   end

   assign SW_RDATA = rdata_q;
   assign IRQ = |(ev_q & en_q);

   // ==========================================================
   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);

   load_head_a: assert property ((lk.req && st_q == S_LOAD && idx_q == 4'h0) |->
      lk.tx == LOAD_QUEUE_WRITE_CMD && !lk.last) else $error("queue load head wrong");
   len_byte_a: assert property ((lk.req && st_q == S_LOAD && idx_q == ONE_CNT) |->
      lk.tx == (rd_op_q ? RD_LEN_B : WR_LEN_B)) else $error("length byte wrong");
   // Deselect gap of two half periods holds off the send command by about ten cycles
   start_send_a: assert property ((st_q == S_LOAD && lk.done && last_b) |=>
      st_q == S_START ##[9:11] (lk.req && lk.tx == NEXT_QUEUE_SEND_CMD && lk.last))
      else $error("send command not issued");
   poll_ok_a: assert property ((st_q == S_POLL && lk.done && last_b &&
      lk.rx[STATUS_MSG_BIT]) |=> st_q == S_READ && idx_q == 4'h0) else $error("poll ignored");
   flags_err_a: assert property ((st_q == S_FLAGS && lk.done && last_b &&
      lk.rx != FLAGS_OK) |=> ev_q[EV_FLAGS] && st_q == S_FMON) else $error("flag error missed");
   pec_tx_a: assert property ((lk.req && st_q == S_LOAD &&
      kl == (rd_op_q ? MP_PEC_RD : MP_PEC_WR) && idx_q >= LD_HDR) |-> lk.tx == crc_q)
      else $error("pec byte wrong");
   alive_chk_a: assert property ((st_q == S_READ && lk.done && last_b && alive_q &&
      lk.rx != seed_q + ALIVE_INC) |=> ev_q[EV_ALIVE]) else $error("alive mismatch missed");
   seed_step_a: assert property ((st_q == S_DONE) |=>
      seed_q == $past(seed_q) + SEED_STEP) else $error("seed not advanced");
   lost_msg_a: assert property ((st_q == S_POLL && lk.done && last_b &&
      !lk.rx[STATUS_MSG_BIT] && tout_q >= 16'(POLL_TOUT_CYC)) |=> ev_q[EV_LOST] && st_q == S_FLAGS)
      else $error("lost message missed");
   pec_rx_a: assert property ((st_q == S_READ && lk.done && idx_q != 4'h0 &&
      kr == (rd_op_q ? MP_RPEC_RD : MP_PEC_WR) && lk.rx != crc_q) |=> ev_q[EV_PEC])
      else $error("pec mismatch missed");

   write_done_c: cover property ((st_q == S_DONE && !rd_op_q && ev_q == '0));
   read_done_c: cover property ((st_q == S_READ && lk.done && last_b && rd_op_q));
   lost_c: cover property ((ev_set[EV_LOST]));
   clear_c: cover property ((st_q == S_CLEAR && lk.done && last_b));
endmodule

/* File: umqs_pkg.sv */
// Shared constants and types of the bridge message sequencer (host side).
// Assumes a single 40 MHz core clock; all SPI timing derives from it.
package umqs_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_NS = 25;
   localparam int SPI_HALF_NS = 125;
   localparam int SPI_HALF_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] SPI_DIV_LAST = 3'(SPI_HALF_CYC - 1);
   localparam int POLL_TOUT_US = 1000;
   localparam int POLL_TOUT_CYC_DEF = POLL_TOUT_US * 1000 / CLK_NS;
   // ==========================================================
   // Bridge command bytes
   localparam logic [7:0] LOAD_QUEUE_WRITE_CMD = 8'hc0;
   localparam logic [7:0] NEXT_QUEUE_SEND_CMD = 8'hb0;
   localparam logic [7:0] NEXT_MESSAGE_READ_CMD = 8'h93;
   localparam logic [7:0] RX_STATUS_RD_CMD = 8'h01;
   localparam logic [7:0] RX_FLAGS_RD_CMD = 8'h09;
   localparam logic [7:0] RX_FLAGS_WR_CMD = 8'h08;
   localparam logic [7:0] FAULT_MON_RD_DEF = 8'h00;
   localparam logic [7:0] DUMMY_BYTE = 8'h00;
   localparam logic [7:0] FLAGS_OK = 8'h00;
   localparam logic [7:0] FLAGS_CLR = 8'h00;
   localparam int STATUS_MSG_BIT = 1;
   // ==========================================================
   // Chain message layout
   localparam int NUM_DEV = 2;
   localparam logic [7:0] BROADCAST_WRITE_MSG = 8'h02;
   localparam logic [7:0] BROADCAST_READ_MSG = 8'h03;
   localparam logic [7:0] DC_SEED = 8'h00;
   localparam logic [7:0] PEC_INIT = 8'h00;
   localparam logic [7:0] PEC_POLY = 8'h07;
   localparam logic [7:0] ALIVE_INC = 8'(NUM_DEV);
   localparam logic [7:0] SEED_STEP = 8'h01;
   localparam int WR_LEN = 6;
   localparam int RD_LOAD_LEN = 5;
   localparam int RD_LEN = RD_LOAD_LEN + 2 * NUM_DEV;
   localparam logic [7:0] WR_LEN_B = 8'(WR_LEN);
   localparam logic [7:0] RD_LEN_B = 8'(RD_LEN);
   localparam logic [3:0] LD_HDR = 4'h2;
   localparam logic [3:0] LD_WR_CNT = 4'(2 + WR_LEN);
   localparam logic [3:0] LD_RD_CNT = 4'(2 + RD_LOAD_LEN);
   localparam logic [3:0] RX_HDR = 4'h1;
   localparam logic [3:0] RX_WR_CNT = 4'(1 + WR_LEN);
   localparam logic [3:0] RX_RD_CNT = 4'(1 + RD_LEN);
   localparam logic [3:0] ONE_CNT = 4'h1;
   localparam logic [3:0] TWO_CNT = 4'h2;
   localparam logic [3:0] MP_ADDR = 4'h1;
   localparam logic [3:0] MP_LO = 4'h2;
   localparam logic [3:0] MP_HI = 4'h3;
   localparam logic [3:0] MP_PEC_WR = 4'h4;
   localparam logic [3:0] MP_PEC_RD = 4'h3;
   localparam logic [3:0] MP_DATA0 = 4'h2;
   localparam logic [3:0] MP_DC_RD = 4'(2 + 2 * NUM_DEV);
   localparam logic [3:0] MP_RPEC_RD = 4'(3 + 2 * NUM_DEV);
   localparam int DEV0_LO = 2 * (NUM_DEV - 1);
   localparam int DEV1_LO = 2 * (NUM_DEV - 2);
   // ==========================================================
   // Software registers
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_EVT = 4'h4;
   localparam logic [3:0] REG_EVCLR = 4'h5;
   localparam logic [3:0] REG_EVEN = 4'h6;
   localparam logic [3:0] REG_FLAGS = 4'h7;
   localparam logic [3:0] REG_DEV0 = 4'h8;
   localparam logic [3:0] REG_DEV1 = 4'h9;
   localparam int CTRL_GO = 0;
   localparam int CTRL_READ = 1;
   localparam int CTRL_ALIVE = 2;
   localparam int EV_W = 7;
   localparam int EV_DONE = 0;
   localparam int EV_PEC = 1;
   localparam int EV_ALIVE = 2;
   localparam int EV_CHECK = 3;
   localparam int EV_LOST = 4;
   localparam int EV_FLAGS = 5;
   localparam int EV_FAULT = 6;
   // ==========================================================
   // State types
   typedef enum logic [1:0] {SP_IDLE, SP_LOW, SP_HIGH, SP_GAP} umqs_spi_state_type;
   typedef enum logic [3:0] {
      S_IDLE, S_LOAD, S_START, S_POLL, S_READ, S_FLAGS, S_FMON, S_CLEAR, S_DONE
   } umqs_state_type;
endpackage

/* File: umqs_byte_if.sv */
// Byte channel between the sequencer and the SPI byte engine.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface umqs_byte_if;
   logic req;
   logic last;
   logic [7:0] tx;
   logic ready;
   logic done;
   logic [7:0] rx;
   modport master (output req, output last, output tx, input ready, input done, input rx);
   modport engine (input req, input last, input tx, output ready, output done, output rx);
endinterface

/* File: umqs_crc8.sv */
// Byte-wise CRC-8 step, purely combinational.
// Assumes the caller holds the running value in its own register.
`timescale 1ns/1ps
module umqs_crc8
   import umqs_pkg::*;
#(
   parameter logic [7:0] POLY = PEC_POLY
) (
   input wire logic [7:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [7:0] crc_out
);
   logic [7:0] c;
   // ==========================================================
   // Eight shift steps, MSB first
   always_comb begin
      c = crc_in ^ data_in;
      for (int i = 0; i < 8; i++) begin
         c = {c[6:0], 1'b0} ^ (c[7] ? POLY : 8'h00);
      end
      crc_out = c;
   end
endmodule

/* File: umqs_spi_byte.sv */
// SPI mode-0 byte engine: shifts one byte per request, MSB first.
// Assumes MISO is synchronous to the core clock; chip select drops with the
// first byte and rises after the byte flagged last.
`timescale 1ns/1ps
module umqs_spi_byte
   import umqs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   umqs_byte_if.engine lk,
   input wire logic miso,
   output logic mosi,
   output logic sclk,
   output logic cs_n
);
   umqs_spi_state_type sp_q, sp_d;
   logic [2:0] div_q, div_d;
   logic [7:0] sh_q, sh_d, rxs_q, rxs_d;
   logic [2:0] bit_q, bit_d;
   logic last_q, last_d, sclk_q, sclk_d, cs_n_q, cs_n_d;
   logic tick;

   // ==========================================================
   // Half-period divider, restarted while idle so each phase is full
   assign tick = (div_q == SPI_DIV_LAST);
   assign div_d = (sp_q == SP_IDLE || tick) ? 3'h0 : div_q + 3'h1;

   // ==========================================================
   // Shift sequencing
   always_comb begin
      sp_d = sp_q;
      sh_d = sh_q;
      rxs_d = rxs_q;
      bit_d = bit_q;
      last_d = last_q;
      sclk_d = sclk_q;
      cs_n_d = cs_n_q;
      lk.done = 1'b0;
      case (sp_q)
         SP_IDLE: begin
            if (lk.req) begin
               sh_d = lk.tx;
               last_d = lk.last;
               cs_n_d = 1'b0;
               bit_d = 3'h0;
               sp_d = SP_LOW;
            end
         end
         SP_LOW: begin
            if (tick) begin
               sclk_d = 1'b1;
               rxs_d = {rxs_q[6:0], miso};
               sp_d = SP_HIGH;
            end
         end
         SP_HIGH: begin
            if (tick) begin
               sclk_d = 1'b0;
               sh_d = {sh_q[6:0], 1'b0};
               bit_d = bit_q + 3'h1;
               sp_d = SP_LOW;
               if (bit_q == 3'h7) begin
                  lk.done = 1'b1;
                  sp_d = last_q ? SP_GAP : SP_IDLE;
               end
            end
         end
         SP_GAP: begin
            // Two ticks: deselect, then hold, so select stays high a full phase
            if (tick) begin
               if (cs_n_q) begin
                  sp_d = SP_IDLE;
               end else begin
                  cs_n_d = 1'b1;
               end
            end
         end
         default: sp_d = SP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_q <= SP_IDLE;
         div_q <= 3'h0;
         sh_q <= 8'h00;
         rxs_q <= 8'h00;
         bit_q <= 3'h0;
         last_q <= 1'b0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sp_q <= sp_d;
         div_q <= div_d;
         sh_q <= sh_d;
         rxs_q <= rxs_d;
         bit_q <= bit_d;
         last_q <= last_d;
         sclk_q <= sclk_d;
         cs_n_q <= cs_n_d;
      end
   end

   assign lk.ready = (sp_q == SP_IDLE);
   assign lk.rx = rxs_q;
   assign mosi = sh_q[7];
   assign sclk = sclk_q;
   assign cs_n = cs_n_q;
endmodule

/* File: umqs_bridge_model.sv */
// Bridge model: SPI mode-0 slave with a load queue and a one-message receive buffer.
// Assumes the host idles SCLK low and frames every command with chip select.
`timescale 1ns/1ps
module umqs_bridge_model (
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   input wire logic drop,
   input wire logic [7:0] flags,
   input wire logic [7:0] skew
);
   logic [7:0] q [0:15];
   logic [7:0] rb [0:15];
   logic [7:0] sr, cmd, ob;
   logic [3:0] nb, ph, ix;
   logic full = 1'b0;
   logic [15:0] dev = 16'h0000;
   // Released line shows the inverse, so a stale bit never passes for data
   assign miso = cs_n ^ ob[3'd7 - ph[2:0]];
   function automatic logic [7:0] crc(input logic [7:0] a, input logic [7:0] d);
      a = a ^ d;
      for (int k = 0; k < 8; k++) a = a[7] ? {a[6:0], 1'b0} ^ 8'h07 : {a[6:0], 1'b0};
      return a;
   endfunction
   // =====================================================================
   // Chain answer: length byte dropped, devices add data and alive steps
   task automatic reply();
      logic [71:0] m;
      logic [7:0] c;
      int n;
      n = (q[1] == 8'h03) ? 9 : 6;
      m = {q[1], q[2], q[3], q[4], q[5], q[6], 24'h0};
      if (n == 9) m = {8'h03, q[2], dev[7:0], dev[15:8], dev[7:0], dev[15:8], 24'h0};
      else dev = {q[4], q[3]};
      c = 8'h00;
      for (int i = 0; i < 9; i++) rb[i] = m[71 - 8 * i -: 8];
      for (int i = 0; i < n - 2; i++) c = crc(c, rb[i]);
      // Nonzero skew corrupts both check bytes, as a damaged chain would
      rb[n - 2] = c + skew;
      rb[n - 1] = q[n == 9 ? 5 : 6] + 8'h02 + skew;
      full = 1'b1;
   endtask
   // New frame restarts the byte count
   always @(negedge cs_n) begin
      nb = 4'h0;
      ph = 4'h0;
      ix = 4'h0;
      ob = 8'h00;
   end
   // Output bit advances on the falling SCLK edge
   always @(negedge sclk) ph = nb;
   // Byte decode on the rising edge of the eighth bit
   always @(posedge sclk) begin
      sr = {sr[6:0], mosi};
      nb = nb + 4'h1;
      if (nb == 4'h8) begin
         nb = 4'h0;
         if (ix == 4'h0) cmd = sr;
         else if (cmd == 8'hc0) q[ix - 4'h1] = sr;
         ob = 8'h00;
         if (cmd == 8'hb0 && !drop) reply();
         if (cmd == 8'h01) ob = {6'h04, full, 1'b0};
         if (cmd == 8'h93) ob = rb[ix];
         if (cmd == 8'h93) full = 1'b0;
         if (cmd == 8'h09) ob = flags;
         ix = ix + 4'h1;
      end
   end
endmodule

/* File: umqs_host_bench.sv */
// Bench: software-port tasks drive jobs against the bridge model.
// Assumes the model answers every job unless told to drop it.
`timescale 1ns/1ps
module umqs_host_bench;
   import umqs_pkg::*;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, drop = 0;
   logic [3:0] addr = 0;
   logic [15:0] wdata = 0;
   logic [7:0] flags = 0, skew = 0;
   logic [15:0] rdata;
   logic irq, sclk, mosi, miso, cs_n;
   int mismatches = 0, comparisons = 0;
   always #12.5 clk = ~clk;
   umqs_host #(.POLL_TOUT_CYC(2000)) uut (.CORE_CLK(clk), .NRST(nrst), .SW_ADDR(addr),
      .SW_WDATA(wdata), .SW_WR(wr), .SW_RD(rd), .SW_RDATA(rdata), .IRQ(irq),
      .SPI_SCLK(sclk), .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_CS_N(cs_n));
   umqs_bridge_model bridge (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .drop(drop), .flags(flags), .skew(skew));
   // =====================================================================
   // Port tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task automatic wrt(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] mk, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata & mk, exp, "read data");
   endtask
   // Bounded wait, the interrupt marks the end of a job
   task automatic job(input logic [15:0] ctrl);
      wrt(REG_EVCLR, 16'h007f);
      wrt(REG_CTRL, ctrl);
      rdc(REG_STATUS, 16'h0100, 16'h0100);
      for (int n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge clk);
      chk(irq, 16'h0001, "no interrupt");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog well beyond six jobs
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
   // =====================================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rdc(REG_EVT, 16'hffff, 16'h0000);
      rdc(4'hf, 16'hffff, 16'h0000);
      wrt(REG_EVEN, 16'h0001);
      wrt(REG_ADDR, 16'h0012);
      wrt(REG_WDATA, 16'hb2b1);
      job(16'h0005);
      rdc(REG_EVT, 16'h007f, 16'h0001);
      wrt(REG_EVEN, 16'h0000);
      #1 chk(irq, 16'h0000, "masked");
      // Re-enable before the next job, its end is seen through the interrupt
      wrt(REG_EVEN, 16'h0001);
      job(16'h0007);
      rdc(REG_EVT, 16'h007f, 16'h0001);
      rdc(REG_CTRL, 16'hffff, 16'h0006);
      rdc(REG_DEV0, 16'hffff, 16'hb2b1);
      rdc(REG_DEV1, 16'hffff, 16'hb2b1);
      rdc(REG_STATUS, 16'h00ff, 16'h0012);
      flags <= 8'h04;
      job(16'h0005);
      rdc(REG_EVT, 16'h0020, 16'h0020);
      rdc(REG_FLAGS, 16'h00ff, 16'h0004);
      flags <= 8'h00;
      drop <= 1'b1;
      job(16'h0005);
      rdc(REG_EVT, 16'h0010, 16'h0010);
      drop <= 1'b0;
      // Corrupted check bytes: PEC always flagged, alive only when checked
      skew <= 8'h01;
      job(16'h0005);
      rdc(REG_EVT, 16'h0006, 16'h0006);
      job(16'h0001);
      rdc(REG_EVT, 16'h0006, 16'h0002);
      give_verdict();
   end
endmodule
